// ---- rtl/clk_switch_pkg.sv ----
// Constants, field layout and helper function for the CPU clock switch control
// Functional notes
// - Status bit 5 shows active clock source
// - Divider bits 0-2 set main instruction time
// - Stop bit 7 ignored while on main clock
// - Main oscillator stops after switch to subsystem
// - Subsystem instruction time fixed, divider ignored
// - Watchdog counting halts on subsystem clock
// - New setting takes effect after old instructions
// - Divider change latency one to sixteen instructions
// - Latency counted in old clock instructions
// - Main-to-subsystem latency bounded by frequency ratio
// - Reset release waits 2^17 oscillator periods
// - Execution starts at slowest main clock setting
// - Clearing stop bit on subsystem restarts oscillator
// - Reset loads control 04H, mode 00H
// - Oscillator stopped while reset is held
// - Mode bit picks oscillator or half rate
package clk_switch_pkg;

	// ****************************************************************
	// Clock rates and timing
	// ****************************************************************
	localparam int CLK_HZ           = 50_000_000;
	localparam int MAIN_OSC_HZ      = 5_000_000;
	localparam int OSC_CYCLES       = CLK_HZ / MAIN_OSC_HZ;
	localparam int STAB_OSC_PERIODS = 131072;
	localparam int STAB_W           = 18;
	localparam int PSC_W            = 5;
	localparam int OSC_W            = 4;

	localparam logic [OSC_W-1:0] OSC_LAST     = OSC_W'(OSC_CYCLES - 1);
	localparam logic [1:0]       SUB_CNT_LAST = 2'h3;

	// ****************************************************************
	// Register map and fields
	// ****************************************************************
	localparam int ADDR_W = 4;

	localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
	localparam logic [ADDR_W-1:0] MODE_OFS = 4'h4;

	localparam int DIV_LSB    = 0;
	localparam int DIV_MSB    = 2;
	localparam int SEL_BIT    = 4;
	localparam int STATUS_BIT = 5;
	localparam int FB_OFF_BIT = 6;
	localparam int STOP_BIT   = 7;
	localparam int BYPASS_BIT = 0;

	localparam logic [7:0] CTRL_RST    = 8'h04;
	localparam logic [7:0] MODE_RST    = 8'h00;
	localparam logic [2:0] DIV_SLOWEST = 3'h4;

	typedef enum logic [1:0] {ST_STAB, ST_RUN, ST_DRAIN, ST_ALIGN} sw_state_t;

	// Prescaler bits that must all be one at the last fxx tick of an instruction.
	// One instruction is two CPU clocks, so the period is 2^(div+1) fxx ticks, with div above 4 taken as 4.
	function automatic logic [PSC_W-1:0] instr_mask(input logic [2:0] div);
		logic [2:0] d;
		d = (div > DIV_SLOWEST) ? DIV_SLOWEST : div;
		case (d)
			3'h0:    instr_mask = 5'h01;
			3'h1:    instr_mask = 5'h03;
			3'h2:    instr_mask = 5'h07;
			3'h3:    instr_mask = 5'h0f;
			default: instr_mask = 5'h1f;
		endcase
	endfunction

endpackage

// ---- rtl/cpu_clk_if.sv ----
// Interface between the switch controller and the main clock prescaler
`timescale 1ns/100ps
interface cpu_clk_if;
	import clk_switch_pkg::*;

	logic             fxx_tick;
	logic [2:0]       div;
	logic [PSC_W-1:0] psc;
	logic             instr_tick;

	modport gen  (input fxx_tick, input div, output psc, output instr_tick);
	modport user (output fxx_tick, output div, input psc, input instr_tick);
endinterface

// ---- rtl/main_prescaler.sv ----
// Free-running main clock prescaler with instruction tick decode
`timescale 1ns/100ps
module main_prescaler
	import clk_switch_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	cpu_clk_if.gen    cpu
);

	logic [PSC_W-1:0] psc_q;
	logic [PSC_W-1:0] mask;

	// Never cleared on a divider change, so every setting stays aligned to
	// the same grid and a switch at a common boundary gives full periods
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			psc_q <= '0;
		end else if (cpu.fxx_tick) begin
			psc_q <= psc_q + 5'h01;
		end
	end

	assign mask           = instr_mask(cpu.div);
	assign cpu.psc        = psc_q;
	assign cpu.instr_tick = cpu.fxx_tick && ((psc_q & mask) == mask);

endmodule

// ---- rtl/cpu_clock_switch_control.sv ----
// CPU clock source and divider switch control with Avalon-MM register access
`timescale 1ns/100ps
module cpu_clock_switch_control
	import clk_switch_pkg::*;
#(
	parameter int STAB_PERIODS = STAB_OSC_PERIODS
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic [ADDR_W-1:0] avs_address_i,
	input  wire logic              avs_read_i,
	input  wire logic              avs_write_i,
	input  wire logic [31:0]       avs_writedata_i,
	input  wire logic [3:0]        avs_byteenable_i,
	output logic      [31:0]       avs_readdata_o,
	output logic                   avs_waitrequest_o,
	input  wire logic              sub_clk_i,
	output logic                   cpu_instr_tick_o,
	output logic                   cpu_run_o,
	output logic                   main_osc_run_o,
	output logic                   sub_fb_off_o,
	output logic                   wdt_count_en_o,
	output logic                   active_clock_status_o
);

	localparam logic [STAB_W-1:0] STAB_LAST = STAB_W'(STAB_PERIODS - 1);

	cpu_clk_if cpu ();

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic              main_osc_stop_q;
	logic              fb_off_q;
	logic              clock_source_select_q;
	logic [2:0]        div_q;
	logic              prescaler_bypass_q;
	logic              cur_sel_q;
	logic [2:0]        cur_div_q;
	logic              tgt_sel_q;
	logic [2:0]        tgt_div_q;
	sw_state_t         state_q;
	sw_state_t         state_d;
	logic [STAB_W-1:0] stab_cnt_q;
	logic              osc_run_q;
	logic              osc_run_d;
	logic              run_q;
	logic [1:0]        sub_cnt_q;
	logic              tick_q;
	logic [OSC_W-1:0]  osc_cnt_q;
	logic              half_q;
	logic              sub_meta_q;
	logic              sub_sync_q;
	logic              sub_prev_q;
	logic              ack_q;
	logic [7:0]        rdata_q;

	// ****************************************************************
	// Clock enables
	// ****************************************************************
	logic osc_tick;
	logic fxx_tick;
	logic fxt_tick;
	logic sub_instr;
	logic main_instr;
	logic old_tick;

	// No oscillator edges while the oscillator is stopped
	assign osc_tick = osc_run_q && (osc_cnt_q == OSC_LAST);
	assign fxx_tick = osc_tick && (prescaler_bypass_q || half_q);
	assign fxt_tick = sub_sync_q && !sub_prev_q;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			osc_cnt_q <= '0;
			half_q    <= 1'b0;
		end else if (osc_run_q) begin
			osc_cnt_q <= osc_tick ? '0 : osc_cnt_q + 4'h1;
			half_q    <= osc_tick ? !half_q : half_q;
		end
	end

	// Subsystem clock pin is asynchronous to clk_i
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sub_meta_q <= 1'b0;
			sub_sync_q <= 1'b0;
			sub_prev_q <= 1'b0;
		end else begin
			sub_meta_q <= sub_clk_i;
			sub_sync_q <= sub_meta_q;
			sub_prev_q <= sub_sync_q;
		end
	end

	assign cpu.fxx_tick = fxx_tick;
	assign cpu.div      = cur_div_q;

	main_prescaler u_psc (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.cpu   (cpu)
	);

	// Subsystem: CPU clock is fxt/2, instruction is four fxt periods
	assign sub_instr  = fxt_tick && (sub_cnt_q == SUB_CNT_LAST);
	assign main_instr = cpu.instr_tick;
	assign old_tick   = cur_sel_q ? sub_instr : main_instr;

	// ****************************************************************
	// Register bus
	// ****************************************************************
	logic       req;
	logic       acc;
	logic       hit_ctrl;
	logic       hit_mode;
	logic       wr_lane0;
	logic [7:0] ctrl_view;
	logic [7:0] rd_byte;

	// One wait state: the request is taken at the second edge
	assign req               = avs_read_i || avs_write_i;
	assign acc               = req && ack_q;
	assign avs_waitrequest_o = req && !ack_q;
	assign hit_ctrl          = (avs_address_i == CTRL_OFS);
	assign hit_mode          = (avs_address_i == MODE_OFS);
	assign wr_lane0          = avs_write_i && acc && avs_byteenable_i[0];

	// Bit 3 is fixed at zero; status bit reads the completed source
	assign ctrl_view = {main_osc_stop_q, fb_off_q, cur_sel_q, clock_source_select_q, 1'b0, div_q};

	always_comb begin
		if (hit_ctrl) begin
			rd_byte = ctrl_view;
		end else if (hit_mode) begin
			rd_byte = {7'h00, prescaler_bypass_q};
		end else begin
			rd_byte = 8'h00;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_q   <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			ack_q   <= req && !ack_q;
			rdata_q <= (req && !ack_q) ? rd_byte : rdata_q;
		end
	end

	assign avs_readdata_o = {24'h000000, rdata_q};

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			main_osc_stop_q       <= CTRL_RST[STOP_BIT];
			fb_off_q              <= CTRL_RST[FB_OFF_BIT];
			clock_source_select_q <= CTRL_RST[SEL_BIT];
			div_q                 <= CTRL_RST[DIV_MSB:DIV_LSB];
			prescaler_bypass_q    <= MODE_RST[BYPASS_BIT];
		end else if (wr_lane0 && hit_ctrl) begin
			main_osc_stop_q       <= avs_writedata_i[STOP_BIT];
			fb_off_q              <= avs_writedata_i[FB_OFF_BIT];
			clock_source_select_q <= avs_writedata_i[SEL_BIT];
			div_q                 <= avs_writedata_i[DIV_MSB:DIV_LSB];
		end else if (wr_lane0 && hit_mode) begin
			prescaler_bypass_q    <= avs_writedata_i[BYPASS_BIT];
		end
	end

	// ****************************************************************
	// Switchover sequencing
	// ****************************************************************
	logic             pending;
	logic [PSC_W-1:0] join_m;
	logic [PSC_W-1:0] new_m;
	logic             join_edge;
	logic             new_edge;
	logic             apply;

	assign pending   = (clock_source_select_q != cur_sel_q) || (div_q != cur_div_q);
	// Waiting for the coarser of both grids bounds the latency at 16 old instructions
	assign join_m    = instr_mask(cur_div_q) | instr_mask(tgt_div_q);
	assign new_m     = instr_mask(tgt_div_q);
	assign join_edge = fxx_tick && ((cpu.psc & join_m) == join_m);
	assign new_edge  = fxx_tick && ((cpu.psc & new_m) == new_m);

	// Switches only on a boundary of the old clock, then of the new one,
	// so neither source yields a shortened CPU period
	always_comb begin
		state_d = state_q;
		apply   = 1'b0;
		case (state_q)
			ST_STAB: begin
				if (osc_tick && (stab_cnt_q == STAB_LAST)) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (pending) begin
					state_d = ST_DRAIN;
				end
			end
			ST_DRAIN: begin
				if (cur_sel_q) begin
					if (sub_instr && tgt_sel_q) begin
						apply   = 1'b1;
						state_d = ST_RUN;
					end else if (sub_instr) begin
						state_d = ST_ALIGN;
					end
				end else if (tgt_sel_q) begin
					if (main_instr) begin
						state_d = ST_ALIGN;
					end
				end else if (join_edge) begin
					apply   = 1'b1;
					state_d = ST_RUN;
				end
			end
			default: begin
				if (tgt_sel_q ? fxt_tick : new_edge) begin
					apply   = 1'b1;
					state_d = ST_RUN;
				end
			end
		endcase
	end

	// A divider written together with a rising select is carried along but unused
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tgt_sel_q <= CTRL_RST[SEL_BIT];
			tgt_div_q <= DIV_SLOWEST;
		end else if (state_q == ST_RUN && pending) begin
			tgt_sel_q <= clock_source_select_q;
			tgt_div_q <= div_q;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cur_sel_q <= CTRL_RST[SEL_BIT];
			cur_div_q <= DIV_SLOWEST;
		end else if (apply) begin
			cur_sel_q <= tgt_sel_q;
			cur_div_q <= tgt_div_q;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sub_cnt_q <= 2'h0;
		end else if (apply) begin
			sub_cnt_q <= 2'h0;
		end else if (fxt_tick) begin
			sub_cnt_q <= sub_cnt_q + 2'h1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q    <= ST_STAB;
			stab_cnt_q <= '0;
			run_q      <= 1'b0;
		end else begin
			state_q    <= state_d;
			stab_cnt_q <= (state_q == ST_STAB && osc_tick) ? stab_cnt_q + 18'h00001 : stab_cnt_q;
			run_q      <= run_q || (state_d != ST_STAB);
		end
	end

	// ****************************************************************
	// Oscillator and CPU outputs
	// ****************************************************************
	// The stop bit only bites once the completed source is the subsystem clock
	always_comb begin
		if (state_q == ST_STAB) begin
			osc_run_d = 1'b1;
		end else begin
			osc_run_d = !(main_osc_stop_q && cur_sel_q);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			osc_run_q <= 1'b0;
			tick_q    <= 1'b0;
		end else begin
			osc_run_q <= osc_run_d;
			tick_q    <= run_q && old_tick;
		end
	end

	// Stop-mode entry on the subsystem clock is software's duty; nothing here blocks it
	assign cpu_instr_tick_o      = tick_q;
	assign cpu_run_o             = run_q;
	assign main_osc_run_o        = osc_run_q;
	assign sub_fb_off_o          = fb_off_q;
	assign wdt_count_en_o        = run_q && !cur_sel_q;
	assign active_clock_status_o = cur_sel_q;

endmodule

// ---- tb/cpu_clock_switch_control_monitor.sv ----
// Port-level assertion checker for the CPU clock switch control
`timescale 1ns/100ps
module cpu_clock_switch_control_monitor
	import clk_switch_pkg::*;
#(
	parameter int STAB_PERIODS = STAB_OSC_PERIODS
) (
	input wire logic              clk_i,
	input wire logic              rst_i,
	input wire logic [ADDR_W-1:0] avs_address_i,
	input wire logic              avs_read_i,
	input wire logic              avs_write_i,
	input wire logic [31:0]       avs_writedata_i,
	input wire logic [3:0]        avs_byteenable_i,
	input wire logic [31:0]       avs_readdata_o,
	input wire logic              avs_waitrequest_o,
	input wire logic              sub_clk_i,
	input wire logic              cpu_instr_tick_o,
	input wire logic              cpu_run_o,
	input wire logic              main_osc_run_o,
	input wire logic              sub_fb_off_o,
	input wire logic              wdt_count_en_o,
	input wire logic              active_clock_status_o
);
	localparam int STAB_CLK = STAB_PERIODS * OSC_CYCLES;
	logic [7:0]  gap_q;
	logic [21:0] rel_q;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Saturating, so a long run never wraps into a false short gap
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			gap_q <= 8'hff;
			rel_q <= 22'h0;
		end else begin
			gap_q <= cpu_instr_tick_o ? 8'h01 : gap_q + {7'h0, gap_q != 8'hff};
			rel_q <= rel_q + {21'h0, rel_q != 22'h3fffff};
		end
	end

	sequence ctrl_wr;
		avs_write_i && !avs_waitrequest_o && avs_address_i == CTRL_OFS && avs_byteenable_i[0];
	endsequence

	// ****
	// Properties
	// ****
	AST_OSC_RESET: assert property ($fell(rst_i) |-> !main_osc_run_o ##1 main_osc_run_o)
		else $error("oscillator start after reset wrong");
	AST_STAB_WAIT: assert property ($rose(cpu_run_o) |-> rel_q >= STAB_CLK - 5 && rel_q <= STAB_CLK + 25)
		else $error("stabilisation wait length wrong");
	AST_WDT_HALT: assert property (wdt_count_en_o == (cpu_run_o && !active_clock_status_o))
		else $error("watchdog enable wrong");
	AST_TICK_GAP: assert property (cpu_instr_tick_o |-> gap_q >= 8'h14)
		else $error("instruction period too short");
	AST_MAIN_KEEP: assert property (cpu_run_o && !active_clock_status_o |-> main_osc_run_o)
		else $error("oscillator stopped on main clock");
	AST_OSC_STOP: assert property ($fell(main_osc_run_o) |-> active_clock_status_o)
		else $error("oscillator stopped before switchover");
	AST_OSC_RESTART: assert property (ctrl_wr ##0 (active_clock_status_o && !avs_writedata_i[STOP_BIT])
		|-> ##[1:2] main_osc_run_o) else $error("oscillator not restarted");
	AST_STATUS_LATE: assert property (ctrl_wr ##0 (avs_writedata_i[SEL_BIT] && !active_clock_status_o)
		|=> !active_clock_status_o) else $error("status changed at write");
	AST_STATUS_READ: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == CTRL_OFS
		|-> avs_readdata_o[STATUS_BIT] == active_clock_status_o && avs_readdata_o[31:8] == 24'h0)
		else $error("status bit readback wrong");
endmodule

bind cpu_clock_switch_control cpu_clock_switch_control_monitor #(.STAB_PERIODS(STAB_PERIODS)) mon_i (.clk_i, .rst_i,
	.avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
	.avs_waitrequest_o, .sub_clk_i, .cpu_instr_tick_o, .cpu_run_o, .main_osc_run_o, .sub_fb_off_o,
	.wdt_count_en_o, .active_clock_status_o);

// ---- tb/cpu_clock_switch_control_tb.sv ----
// Self-checking testbench for the CPU clock switch control
`timescale 1ns/100ps
module cpu_clock_switch_control_tb import clk_switch_pkg::*; ;
	localparam int STAB = 8;
	logic              clk_i = 1'b0;
	logic              rst_i = 1'b1;
	logic [ADDR_W-1:0] avs_address_i = 4'h0;
	logic              avs_read_i = 1'b0;
	logic              avs_write_i = 1'b0;
	logic [31:0]       avs_writedata_i = 32'h0;
	logic [3:0]        avs_byteenable_i = 4'h1;
	logic [31:0]       avs_readdata_o;
	logic              avs_waitrequest_o;
	logic              sub_clk_i = 1'b0;
	logic              cpu_instr_tick_o;
	logic              cpu_run_o;
	logic              main_osc_run_o;
	logic              sub_fb_off_o;
	logic              wdt_count_en_o;
	logic              active_clock_status_o;
	int                failures = 0;
	int                cmp_count = 0;
	int                cyc = 0;
	int                p;
	logic [31:0]       rd;

	cpu_clock_switch_control #(.STAB_PERIODS(STAB)) cpu_clock_switch_control_i (.clk_i, .rst_i, .avs_address_i,
		.avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
		.sub_clk_i, .cpu_instr_tick_o, .cpu_run_o, .main_osc_run_o, .sub_fb_off_o, .wdt_count_en_o,
		.active_clock_status_o);

	always #10 clk_i = ~clk_i;

	// ****
	// Free-running sub crystal, stable long before any switch; run ceiling
	// ****
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc % 763 == 762) begin
			sub_clk_i <= ~sub_clk_i;
		end
		if (cyc == 90000) begin
			failures++;
			results();
		end
	end

	task automatic results();
		$display("checks %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s exp %h seen %h", name, exp, seen);
		end
	endtask

	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= {24'h0, d};
		avs_write_i <= wr;
		avs_read_i <= ~wr;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 20);
		rd = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		check("waitrequest", avs_waitrequest_o, 1'b0);
	endtask

	// Cycles between two instruction ticks
	task automatic period();
		int n;
		n = 0;
		while (cpu_instr_tick_o !== 1'b1 && n < 8000) begin
			@(posedge clk_i);
			n++;
		end
		@(posedge clk_i);
		p = 1;
		while (cpu_instr_tick_o !== 1'b1 && p < 8000) begin
			@(posedge clk_i);
			p++;
		end
	endtask

	// A new divider may lag by up to 16 old instructions
	task automatic settle(input string name, input int exp);
		int k;
		k = 0;
		period();
		while (p != exp && k < 17) begin
			period();
			k++;
		end
		check(name, p, exp);
	endtask

	task automatic wait_status(input logic v, input int lim);
		int n;
		n = 0;
		while (active_clock_status_o !== v && n < lim) begin
			@(posedge clk_i);
			n++;
		end
	endtask

	// ****
	// Scenarios
	// ****
	task automatic t_reset();
		bus(1'b0, CTRL_OFS, 8'h0);
		check("ctrl reset", rd, 32'h04);
		check("run early", cpu_run_o, 1'b0);
		bus(1'b0, MODE_OFS, 8'h0);
		check("mode reset", rd, 32'h0);
		bus(1'b0, 4'h8, 8'h0);
		check("unmapped", rd, 32'h0);
		repeat (STAB * OSC_CYCLES + 20) @(posedge clk_i);
		check("run", cpu_run_o, 1'b1);
		period();
		check("slowest", p, 640);
		check("fb off reset", sub_fb_off_o, 1'b0);
		// A write without lane 0 must leave the register alone
		avs_byteenable_i <= 4'h0;
		bus(1'b1, CTRL_OFS, 8'h44);
		avs_byteenable_i <= 4'h1;
		bus(1'b0, CTRL_OFS, 8'h0);
		check("no lane", rd, 32'h04);
		bus(1'b1, CTRL_OFS, 8'h44);
		bus(1'b0, CTRL_OFS, 8'h0);
		check("fb off read", rd, 32'h44);
		check("fb off set", sub_fb_off_o, 1'b1);
		bus(1'b1, CTRL_OFS, 8'h04);
		@(posedge clk_i);
		check("fb off clear", sub_fb_off_o, 1'b0);
	endtask

	task automatic t_divider();
		for (int m = 0; m < 2; m++) begin
			bus(1'b1, MODE_OFS, 8'(m));
			// Codes above the slowest setting act as the slowest
			bus(1'b1, CTRL_OFS, 8'h07);
			settle("div7", (20 >> m) << 5);
			for (int d = 0; d < 5; d++) begin
				bus(1'b1, CTRL_OFS, 8'(d));
				settle("div", (20 >> m) << (d + 1));
			end
		end
	endtask

	// No stop-mode request is ever made while on the subsystem clock
	task automatic t_to_sub();
		bus(1'b1, CTRL_OFS, 8'h84);
		repeat (40) @(posedge clk_i);
		check("osc kept", main_osc_run_o, 1'b1);
		bus(1'b1, CTRL_OFS, 8'h94);
		bus(1'b0, CTRL_OFS, 8'h0);
		check("status early", rd, 32'h94);
		wait_status(1'b1, 2000);
		check("status sub", active_clock_status_o, 1'b1);
		check("wdt off", wdt_count_en_o, 1'b0);
		bus(1'b0, CTRL_OFS, 8'h0);
		check("ctrl sub", rd, 32'hb4);
		check("osc stop", main_osc_run_o, 1'b0);
		bus(1'b1, CTRL_OFS, 8'hb0);
		period();
		check("sub period", p, 6104);
	endtask

	task automatic t_back();
		bus(1'b1, CTRL_OFS, 8'h30);
		repeat (3) @(posedge clk_i);
		check("osc on", main_osc_run_o, 1'b1);
		repeat (200) @(posedge clk_i);
		bus(1'b1, CTRL_OFS, 8'h00);
		wait_status(1'b0, 7000);
		check("status main", active_clock_status_o, 1'b0);
		check("wdt on", wdt_count_en_o, 1'b1);
		settle("fast", 20);
	endtask

	initial begin
		repeat (6) @(posedge clk_i);
		check("osc in reset", main_osc_run_o, 1'b0);
		rst_i <= 1'b0;
		t_reset();
		t_divider();
		t_to_sub();
		t_back();
		results();
	end
endmodule
